/* File: rtl/pin_sync.sv */
// Three-stage pin synchroniser with a filtered, agreed level and edges.
// Assumes the input is asynchronous to ref_clk_in.
`timescale 1ns/1ps
module pin_sync
  import timer16_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Level changes only once stages two and three agree
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_out <= 1'b0;
      rise_out  <= 1'b0;
      fall_out  <= 1'b0;
    end else begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      if (s2_reg == s3_reg && s3_reg != level_out) begin
        level_out <= s3_reg;
        rise_out  <= s3_reg;
        fall_out  <= !s3_reg;
      end
    end
  end
endmodule

/* File: rtl/timer16_core.sv */
// 16-bit timer core: byte access through a shared high-byte latch,
// prescaled or pin clock, double-buffered compares, capture, flags.
// Assumes an Avalon-MM master on ref_clk_in and asynchronous pins.
`timescale 1ns/1ps
module timer16_core
  import timer16_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        ext_count_pin_in,
  input  wire logic        capture_pin_in,
  input  wire logic        comparator_in,
  output logic             wave_out_a_out,
  output logic             wave_out_b_out,
  output logic             irq_req_out,
  output logic             bottom_out,
  output logic             max_out
);
  bus_state_t  bus_state_reg;
  logic [7:0]  latch_reg;
  logic [15:0] count_value;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] cmp_buf_a_reg;
  logic [15:0] cmp_buf_b_reg;
  logic [15:0] capture_value;
  logic [7:0]  control_a;
  logic [7:0]  control_b;
  logic [7:0]  irq_flag_reg;
  logic [7:0]  irq_mask_reg;
  logic [7:0]  power_reduction_reg;
  logic [9:0]  prescale_reg;
  logic        up_reg;
  logic        ext_level;
  logic        ext_rise;
  logic        ext_fall;
  logic        cap_level;
  logic        cap_rise;
  logic        cap_fall;
  logic        cmp_level;
  logic        cmp_rise;
  logic        cmp_fall;

  logic        bus_take;
  logic        wr_take;
  logic        rd_take;
  logic [3:0]  idx;
  logic [7:0]  wbyte;
  logic        count_tick;
  logic        enabled;
  logic [3:0]  wgm;
  logic [15:0] top_val;
  logic        top_hit;
  logic        bot_hit;
  logic        pwm_mode;
  logic        dual_slope;
  logic        match_a;
  logic        match_b;
  logic        cap_evt;
  logic        cap_is_top;
  logic        ovf_evt;
  logic        cnt_wr;
  logic [7:0]  rd_byte;

  pin_sync u_ext_sync (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (ext_count_pin_in),
    .level_out  (ext_level),
    .rise_out   (ext_rise),
    .fall_out   (ext_fall)
  );
  pin_sync u_cap_sync (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (capture_pin_in),
    .level_out  (cap_level),
    .rise_out   (cap_rise),
    .fall_out   (cap_fall)
  );
  pin_sync u_cmp_sync (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (comparator_in),
    .level_out  (cmp_level),
    .rise_out   (cmp_rise),
    .fall_out   (cmp_fall)
  );

  assign idx      = address[5:2];
  assign wbyte    = writedata[7:0];
  assign bus_take = (bus_state_reg == BUS_IDLE) && (read || write);
  assign wr_take  = bus_take && write && byteenable[0];
  assign rd_take  = bus_take && read;
  assign cnt_wr   = wr_take && idx == CNT_LO_IDX;
  assign enabled  = !power_reduction_reg[PWR_OFF_BIT];
  assign wgm = {control_b[WGM_HI_LSB+1:WGM_HI_LSB],
                control_a[WGM_LO_LSB+1:WGM_LO_LSB]};
  assign cap_is_top = (wgm == 4'h8) || (wgm == 4'ha) ||
                      (wgm == 4'hc) || (wgm == 4'he);

  // Mode decodes top; compare A top uses the active, buffered copy
  always_comb begin
    top_val    = MAX_VAL;
    pwm_mode   = 1'b1;
    dual_slope = 1'b0;
    case (wgm)
      4'h1, 4'h5: top_val = TOP8_VAL;
      4'h2, 4'h6: top_val = TOP9_VAL;
      4'h3, 4'h7: top_val = TOP10_VAL;
      4'h4, 4'hf, 4'hb, 4'h9: top_val = compare_value_a;
      4'h8, 4'ha, 4'hc, 4'he: top_val = capture_value;
      default: top_val = MAX_VAL;
    endcase
    case (wgm)
      4'h0, 4'h4, 4'hc, 4'hd: pwm_mode = 1'b0;
      default: pwm_mode = 1'b1;
    endcase
    case (wgm)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: dual_slope = 1'b1;
      default: dual_slope = 1'b0;
    endcase
  end

  // prescaler tap or synchronised pin edge; stop gives no tick
  always_comb begin
    case (control_b[CS_LSB+2:CS_LSB])
      CS_DIV1: count_tick = 1'b1;
      CS_DIV8: count_tick = (prescale_reg & DIV8_MASK) == DIV8_MASK;
      CS_D64:  count_tick = (prescale_reg & DIV64_MASK) == DIV64_MASK;
      CS_D256: count_tick = (prescale_reg & DIV256_MASK) == DIV256_MASK;
      CS_D1K:  count_tick = prescale_reg == DIV1024_MASK;
      CS_EXTF: count_tick = ext_fall;
      CS_EXTR: count_tick = ext_rise;
      default: count_tick = 1'b0;
    endcase
    count_tick = count_tick && enabled;
  end

  assign top_hit = count_value == top_val;
  assign bot_hit = count_value == BOTTOM_VAL;
  assign match_a = count_tick && count_value == compare_value_a;
  assign match_b = count_tick && count_value == compare_value_b;
  assign ovf_evt = count_tick &&
                   (dual_slope ? bot_hit && !up_reg
                               : (pwm_mode ? top_hit
                                           : count_value == MAX_VAL));
  // Capture unused while capture register defines top
  assign cap_evt = enabled && !cap_is_top &&
    (control_b[CAP_SRC_BIT]
      ? (control_b[CAP_EDGE_BIT] ? cmp_rise : cmp_fall)
      : (control_b[CAP_EDGE_BIT] ? cap_rise : cap_fall));

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prescale_reg <= 10'h000;
    end else if (enabled) begin
      prescale_reg <= prescale_reg + 10'h001;
    end
  end

  // Bus handshake: request taken in idle, data back one edge later
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: if (read || write) bus_state_reg <= BUS_ACK;
        BUS_ACK:  bus_state_reg <= BUS_DONE;
        BUS_DONE: bus_state_reg <= BUS_IDLE;
        default:  bus_state_reg <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(bus_state_reg == BUS_IDLE && (read || write));
    end
  end

  always_comb begin
    case (idx)
      CNT_LO_IDX:  rd_byte = count_value[7:0];
      CNT_HI_IDX:  rd_byte = latch_reg;
      CMPA_LO_IDX: rd_byte = cmp_buf_a_reg[7:0];
      CMPA_HI_IDX: rd_byte = cmp_buf_a_reg[15:8];
      CMPB_LO_IDX: rd_byte = cmp_buf_b_reg[7:0];
      CMPB_HI_IDX: rd_byte = cmp_buf_b_reg[15:8];
      CAP_LO_IDX:  rd_byte = capture_value[7:0];
      CAP_HI_IDX:  rd_byte = latch_reg;
      CTRL_A_IDX:  rd_byte = control_a;
      CTRL_B_IDX:  rd_byte = control_b;
      FLAG_IDX:    rd_byte = irq_flag_reg;
      MASK_IDX:    rd_byte = irq_mask_reg;
      POWER_IDX:   rd_byte = power_reduction_reg;
      IRQ_IDX:     rd_byte = {6'h00, max_out, bottom_out};
      default:     rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      readdata <= {24'h00_0000, rd_byte};
    end
  end

  // one latch; high-byte writes land here, counter and capture low reads fill it
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      latch_reg <= 8'h00;
    end else if (wr_take && (idx == CNT_HI_IDX || idx == CMPA_HI_IDX ||
                 idx == CMPB_HI_IDX || idx == CAP_HI_IDX)) begin
      latch_reg <= wbyte;
    end else if (rd_take && idx == CNT_LO_IDX) begin
      latch_reg <= count_value[15:8];
    end else if (rd_take && idx == CAP_LO_IDX) begin
      latch_reg <= capture_value[15:8];
    end
  end

  // software write wins over clear and count
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_value <= WORD_RST;
      up_reg      <= 1'b1;
    end else if (cnt_wr) begin
      count_value <= {latch_reg, wbyte};
    end else if (count_tick) begin
      if (dual_slope) begin
        if (up_reg && top_hit) begin
          up_reg      <= 1'b0;
          count_value <= count_value - 16'h0001;
        end else if (!up_reg && bot_hit) begin
          up_reg      <= 1'b1;
          count_value <= count_value + 16'h0001;
        end else begin
          count_value <= up_reg ? count_value + 16'h0001
                                : count_value - 16'h0001;
        end
      end else if (top_hit) begin
        count_value <= BOTTOM_VAL;
      end else begin
        count_value <= count_value + 16'h0001;
      end
    end
  end

  // staged copies, made active at top in PWM modes
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmp_buf_a_reg   <= WORD_RST;
      cmp_buf_b_reg   <= WORD_RST;
      compare_value_a <= WORD_RST;
      compare_value_b <= WORD_RST;
    end else begin
      if (wr_take && idx == CMPA_LO_IDX) begin
        cmp_buf_a_reg <= {latch_reg, wbyte};
      end
      if (wr_take && idx == CMPB_LO_IDX) begin
        cmp_buf_b_reg <= {latch_reg, wbyte};
      end
      // compare A top reloads at the update point in PWM modes; in mode 4 it reloads every cycle
      if (!pwm_mode || (count_tick &&
          (dual_slope ? (top_hit && up_reg) : top_hit))) begin
        compare_value_a <= cmp_buf_a_reg;
        compare_value_b <= cmp_buf_b_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      capture_value <= WORD_RST;
    end else if (wr_take && idx == CAP_LO_IDX && cap_is_top) begin
      capture_value <= {latch_reg, wbyte};
    end else if (cap_evt) begin
      capture_value <= count_value;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      control_a           <= CTRL_RST;
      control_b           <= CTRL_RST;
      irq_mask_reg        <= CTRL_RST;
      power_reduction_reg <= PWR_RST;
    end else if (wr_take) begin
      case (idx)
        CTRL_A_IDX: control_a <= wbyte;
        CTRL_B_IDX: control_b <= wbyte;
        MASK_IDX:   irq_mask_reg <= wbyte & 8'h27;
        POWER_IDX:  power_reduction_reg <= wbyte & 8'h01;
        default:    control_a <= control_a;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_flag_reg <= CTRL_RST;
    end else begin
      irq_flag_reg <= ((wr_take && idx == FLAG_IDX)
                        ? irq_flag_reg & ~wbyte : irq_flag_reg)
        | ({7'h00, ovf_evt} << OVF_BIT)
        | ({7'h00, match_a} << CMPA_BIT)
        | ({7'h00, match_b} << CMPB_BIT)
        | ({7'h00, cap_evt} << CAP_BIT);
    end
  end

  // compare A defining top in PWM holds its output low
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wave_out_a_out <= 1'b0;
      wave_out_b_out <= 1'b0;
      irq_req_out    <= 1'b0;
      bottom_out     <= 1'b0;
      max_out        <= 1'b0;
    end else begin
      if (pwm_mode && (wgm == 4'hf || wgm == 4'hb || wgm == 4'h9)) begin
        wave_out_a_out <= 1'b0;
      end else if (match_a) begin
        wave_out_a_out <= !wave_out_a_out;
      end
      if (match_b) begin
        wave_out_b_out <= !wave_out_b_out;
      end
      irq_req_out <= |(irq_flag_reg & irq_mask_reg);
      bottom_out  <= bot_hit;
      max_out     <= count_value == MAX_VAL;
    end
  end
endmodule

/* File: rtl/timer16_pkg.sv */
// Shared constants for the 16-bit timer core: register map, fields, limits.
// Assumes an Avalon-MM slave with 32-bit words, one byte register per word.
package timer16_pkg;
  // Word offsets (byte address = 4 * index)
  localparam logic [3:0] CNT_LO_IDX   = 4'h0;
  localparam logic [3:0] CNT_HI_IDX   = 4'h1;
  localparam logic [3:0] CMPA_LO_IDX  = 4'h2;
  localparam logic [3:0] CMPA_HI_IDX  = 4'h3;
  localparam logic [3:0] CMPB_LO_IDX  = 4'h4;
  localparam logic [3:0] CMPB_HI_IDX  = 4'h5;
  localparam logic [3:0] CAP_LO_IDX   = 4'h6;
  localparam logic [3:0] CAP_HI_IDX   = 4'h7;
  localparam logic [3:0] CTRL_A_IDX   = 4'h8;
  localparam logic [3:0] CTRL_B_IDX   = 4'h9;
  localparam logic [3:0] FLAG_IDX     = 4'ha;
  localparam logic [3:0] MASK_IDX     = 4'hb;
  localparam logic [3:0] POWER_IDX    = 4'hc;
  localparam logic [3:0] IRQ_IDX      = 4'hd;
  // Flag and mask bit positions
  localparam int OVF_BIT  = 0;
  localparam int CMPA_BIT = 1;
  localparam int CMPB_BIT = 2;
  localparam int CAP_BIT  = 5;
  // control_b fields
  localparam int CS_LSB       = 0;
  localparam int WGM_HI_LSB   = 3;
  localparam int CAP_EDGE_BIT = 6;
  localparam int CAP_SRC_BIT  = 7;
  // control_a fields
  localparam int WGM_LO_LSB   = 0;
  // Power register field
  localparam int PWR_OFF_BIT  = 0;
  // Reset values
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  PWR_RST   = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  // Count limits
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL    = 16'hffff;
  localparam logic [15:0] TOP8_VAL   = 16'h00ff;
  localparam logic [15:0] TOP9_VAL   = 16'h01ff;
  localparam logic [15:0] TOP10_VAL  = 16'h03ff;
  // Prescaler taps, as low-bit masks, one less than the period in clocks
  localparam logic [9:0]  DIV8_MASK    = 10'h007;
  localparam logic [9:0]  DIV64_MASK   = 10'h03f;
  localparam logic [9:0]  DIV256_MASK  = 10'h0ff;
  localparam logic [9:0]  DIV1024_MASK = 10'h3ff;
  // Clock-select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_D64  = 3'h3;
  localparam logic [2:0] CS_D256 = 3'h4;
  localparam logic [2:0] CS_D1K  = 3'h5;
  localparam logic [2:0] CS_EXTF = 3'h6;
  localparam logic [2:0] CS_EXTR = 3'h7;
  // Bus answer states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK  = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;
endpackage

/* File: tb/timer16_byte_access_core_bench.sv */
// Bench for the timer core: byte access, limits, flags, capture, modes.
// Assumes the bus model beside it and a stopped timer out of reset.
`timescale 1ns/1ps
module timer16_byte_access_core_bench
  import timer16_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [5:0]  address;
  logic        read, write;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata;
  logic        waitrequest, wave_a, wave_b, irq, at_bottom, at_max;
  logic        ext_pin = 1'b0;
  logic        cap_pin = 1'b0;
  logic        cmp_pin = 1'b0;
  logic [15:0] v;
  logic [7:0]  b;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [7:0]  mode_a [4] = '{8'h01, 8'h02, 8'h03, 8'h03};
  logic [7:0]  mode_b [4] = '{8'h08, 8'h08, 8'h08, 8'h18};
  logic [15:0] mode_top [4] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'h0040};
  always #25 ref_clk_in = ~ref_clk_in;
  timer16_cpu_model cpu (.ref_clk_in, .address_out(address),
    .read_out(read), .write_out(write), .byteenable_out(byteenable),
    .writedata_out(writedata), .readdata_in(readdata),
    .waitrequest_in(waitrequest));
  timer16_core dut (.ref_clk_in, .arst_n_in, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest,
    .ext_count_pin_in(ext_pin), .capture_pin_in(cap_pin),
    .comparator_in(cmp_pin), .wave_out_a_out(wave_a),
    .wave_out_b_out(wave_b), .irq_req_out(irq),
    .bottom_out(at_bottom), .max_out(at_max));
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic wr8(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] q;
    cpu.xfer(1'b1, i, d, q);
  endtask
  task automatic rd8(input logic [3:0] i);
    cpu.xfer(1'b0, i, 8'h00, b);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 500) begin
      @(posedge ref_clk_in);
      n++;
    end
  endtask
  task automatic t_access();
    cpu.wr16(CNT_LO_IDX, 16'h01ff);
    cpu.rd16(CNT_LO_IDX, v);
    chk(v, 16'h01ff);
    cpu.wr16(CMPA_LO_IDX, 16'hab12);
    wr8(CMPB_HI_IDX, 8'h5a);
    wr8(CNT_LO_IDX, 8'h34);
    cpu.rd16(CNT_LO_IDX, v);
    chk(v, 16'h5a34);
    rd8(CAP_LO_IDX);
    rd8(CMPA_HI_IDX);
    chk({8'h00, b}, 16'h00ab);
    rd8(CNT_HI_IDX);
    chk({8'h00, b}, 16'h0000);
    cpu.rd16(CMPA_LO_IDX, v);
    chk(v, 16'hab12);
    wr8(4'he, 8'h77);
    rd8(4'he);
    chk({8'h00, b}, 16'h0000);
    wr8(MASK_IDX, 8'h27);
    rd8(MASK_IDX);
    chk({8'h00, b}, 16'h0027);
    wr8(MASK_IDX, 8'h00);
  endtask
  task automatic t_limits();
    cpu.wr16(CNT_LO_IDX, MAX_VAL);
    run(3);
    chk({14'h0, at_max, at_bottom}, 16'h0002);
    rd8(IRQ_IDX);
    chk({8'h00, b}, 16'h0002);
    cpu.wr16(CNT_LO_IDX, BOTTOM_VAL);
    run(3);
    chk({14'h0, at_max, at_bottom}, 16'h0001);
  endtask
  task automatic t_flags();
    cpu.wr16(CMPA_LO_IDX, 16'h0020);
    wr8(MASK_IDX, 8'h02);
    wr8(CTRL_B_IDX, {5'h00, CS_DIV1});
    wait_irq();
    wr8(CTRL_B_IDX, 8'h00);
    chk({15'h0, irq}, 16'h0001);
    chk({15'h0, wave_a}, 16'h0001);
    chk({15'h0, wave_b}, 16'h0001);
    rd8(FLAG_IDX);
    chk({8'h00, b & 8'h02}, 16'h0002);
    wr8(FLAG_IDX, 8'hff);
    run(2);
    chk({15'h0, irq}, 16'h0000);
    // Counter write lands while the timer is running
    wr8(CTRL_B_IDX, {5'h00, CS_DIV1});
    cpu.wr16(CNT_LO_IDX, 16'hffe0);
    wr8(MASK_IDX, 8'h01);
    wait_irq();
    wr8(CTRL_B_IDX, 8'h00);
    wr8(MASK_IDX, 8'h00);
    run(2);
    chk({15'h0, irq}, 16'h0000);
    rd8(FLAG_IDX);
    chk({8'h00, b & 8'h01}, 16'h0001);
    cpu.rd16(CNT_LO_IDX, v);
    chk({15'h0, v < 16'h0040}, 16'h0001);
    // Write beats the tick of its own edge, then three ticks to the stop
    wr8(CTRL_B_IDX, {5'h00, CS_DIV1});
    cpu.wr16(CNT_LO_IDX, 16'h1000);
    wr8(CTRL_B_IDX, 8'h00);
    cpu.rd16(CNT_LO_IDX, v);
    chk(v, 16'h1003);
    wr8(FLAG_IDX, 8'hff);
  endtask
  task automatic t_power();
    cpu.wr16(CNT_LO_IDX, MAX_VAL);
    wr8(POWER_IDX, 8'h01);
    wr8(CTRL_B_IDX, {5'h00, CS_DIV1});
    run(20);
    wr8(CTRL_B_IDX, 8'h00);
    wr8(POWER_IDX, 8'h00);
    cpu.rd16(CNT_LO_IDX, v);
    chk(v, MAX_VAL);
  endtask
  task automatic t_pins();
    for (int i = 0; i < 2; i++) begin
      wr8(CTRL_B_IDX, i ? 8'hc0 : 8'h40);
      cpu.wr16(CNT_LO_IDX, 16'h1234 + 16'(i));
      wr8(FLAG_IDX, 8'hff);
      if (i) cmp_pin <= 1'b1;
      else cap_pin <= 1'b1;
      run(8);
      cpu.rd16(CAP_LO_IDX, v);
      chk(v, 16'h1234 + 16'(i));
      rd8(FLAG_IDX);
      chk({8'h00, b & 8'h20}, 16'h0020);
    end
    for (int i = 0; i < 2; i++) begin
      wr8(CTRL_B_IDX, {5'h00, i ? CS_EXTF : CS_EXTR});
      cpu.wr16(CNT_LO_IDX, 16'h0000);
      repeat (3) begin
        ext_pin <= 1'b1;
        run(6);
        ext_pin <= 1'b0;
        run(6);
      end
      wr8(CTRL_B_IDX, 8'h00);
      cpu.rd16(CNT_LO_IDX, v);
      chk(v, 16'h0003);
    end
  endtask
  task automatic t_tops();
    cpu.wr16(CMPA_LO_IDX, 16'h0040);
    for (int i = 0; i < 4; i++) begin
      wr8(CTRL_A_IDX, mode_a[i]);
      cpu.wr16(CNT_LO_IDX, mode_top[i] - 16'h0008);
      wr8(CTRL_B_IDX, mode_b[i] | 8'h01);
      run(60);
      wr8(CTRL_B_IDX, mode_b[i]);
      cpu.rd16(CNT_LO_IDX, v);
      chk({15'h0, v <= mode_top[i]}, 16'h0001);
    end
    chk({15'h0, wave_a}, 16'h0000);
    wr8(CTRL_A_IDX, 8'h00);
    wr8(CTRL_B_IDX, 8'h00);
  endtask
  initial begin
    run(4);
    arst_n_in <= 1'b1;
    t_access();
    t_limits();
    t_flags();
    t_power();
    t_pins();
    t_tops();
    stop_test();
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end
endmodule

/* File: tb/timer16_checker.sv */
// Port assertions for the timer core, bound to every instance.
// Assumes byte registers at word indices and one bus master.
`timescale 1ns/1ps
module timer16_checker
  import timer16_pkg::*;
(
  input logic        ref_clk_in,
  input logic        arst_n_in,
  input logic [5:0]  address,
  input logic        read,
  input logic        write,
  input logic [3:0]  byteenable,
  input logic [31:0] writedata,
  input logic [31:0] readdata,
  input logic        waitrequest,
  input logic        wave_out_a_out,
  input logic        wave_out_b_out,
  input logic        irq_req_out,
  input logic        bottom_out,
  input logic        max_out
);
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] mask_reg;
  logic       power_reg;
  logic       taken;
  logic [3:0] wgm;
  assign taken = write && !waitrequest && byteenable[0];
  assign wgm = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
  // Shadows lag the core by a cycle, hence the repeat margins
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_a_reg <= CTRL_RST;
      ctrl_b_reg <= CTRL_RST;
      mask_reg <= 8'h00;
      power_reg <= 1'b0;
    end else if (taken) begin
      case (address[5:2])
        CTRL_A_IDX: ctrl_a_reg <= writedata[7:0];
        CTRL_B_IDX: ctrl_b_reg <= writedata[7:0];
        MASK_IDX: mask_reg <= writedata[7:0];
        POWER_IDX: power_reg <= writedata[PWR_OFF_BIT];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence s_req_held;
    (read || write) && waitrequest;
  endsequence
  sequence s_stopped;
    (ctrl_b_reg[2:0] == CS_STOP && !power_reg && wgm != 4'h9 &&
     wgm != 4'hb && wgm != 4'hf)[*4];
  endsequence
  sequence s_a_is_top;
    (wgm == 4'h9 || wgm == 4'hb || wgm == 4'hf)[*4];
  endsequence
  a_ack_bound: assert property (s_req_held |-> ##[1:4] !waitrequest)
    else $error("bus answer missing");
  a_ack_cause: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without request");
  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer held too long");
  a_byte_wide: assert property (readdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_limits_apart: assert property (!(bottom_out && max_out))
    else $error("bottom and max together");
  a_idle_steady: assert property (s_stopped |->
    $stable(wave_out_a_out) && $stable(wave_out_b_out))
    else $error("wave moved with no clock");
  a_top_quiet: assert property (s_a_is_top |-> !wave_out_a_out)
    else $error("wave A active while it is top");
  a_mask_quiet: assert property ((mask_reg == 8'h00)[*2] |->
    !irq_req_out)
    else $error("request with all masked");
endmodule

bind timer16_core timer16_checker chk_i (.ref_clk_in, .arst_n_in,
  .address, .read, .write, .byteenable, .writedata, .readdata,
  .waitrequest, .wave_out_a_out, .wave_out_b_out, .irq_req_out,
  .bottom_out, .max_out);

/* File: tb/timer16_cpu_model.sv */
// Bus-master model of the CPU: byte transfers and 16-bit pairs.
// Assumes the core's Avalon-MM slave; this is the only master.
`timescale 1ns/1ps
module timer16_cpu_model (
  input  wire logic        ref_clk_in,
  output logic [5:0]       address_out,
  output logic             read_out,
  output logic             write_out,
  output logic [3:0]       byteenable_out,
  output logic [31:0]      writedata_out,
  input  wire logic [31:0] readdata_in,
  input  wire logic        waitrequest_in
);
  initial begin
    address_out = 6'h00;
    read_out = 1'b0;
    write_out = 1'b0;
    byteenable_out = 4'h1;
    writedata_out = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [3:0] idx,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk_in);
    address_out <= {idx, 2'b00};
    read_out <= !wr;
    write_out <= wr;
    writedata_out <= {24'h0, d};
    do @(posedge ref_clk_in); while (waitrequest_in !== 1'b0);
    q = readdata_in[7:0];
    read_out <= 1'b0;
    write_out <= 1'b0;
    // Released lines show garbage, never the old value
    address_out <= ~address_out;
    writedata_out <= ~writedata_out;
  endtask
  task automatic wr16(input logic [3:0] lo, input logic [15:0] w);
    logic [7:0] q;
    xfer(1'b1, lo + 4'h1, w[15:8], q);
    xfer(1'b1, lo, w[7:0], q);
  endtask
  task automatic rd16(input logic [3:0] lo, output logic [15:0] w);
    xfer(1'b0, lo, 8'h00, w[7:0]);
    xfer(1'b0, lo + 4'h1, 8'h00, w[15:8]);
  endtask
endmodule
